// File: rtl/scs_pkg.sv
package scs_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 100;
  // least wait in crystal mode before the valid flag may rise
  localparam int unsigned XTAL_WAIT_NS       = 1000000;
  localparam int unsigned XTAL_WAIT_CYC      =
    (XTAL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // crystal oscillator edges seen before the source counts as settled
  localparam int unsigned XTAL_SETTLE_EDGES  = 16;
  localparam int unsigned QUICK_SETTLE_EDGES = 4;
  localparam int          CNT_W              = 16;

  typedef enum logic [2:0]
  {
    SCS_XM_OFF     = 3'b000,
    SCS_XM_CRYSTAL = 3'b001,
    SCS_XM_RC      = 3'b010,
    SCS_XM_CAP     = 3'b011,
    SCS_XM_CMOS    = 3'b100
  } scs_xmode_t;

  typedef enum logic [1:0]
  {
    SCS_ST_IDLE  = 2'b00,
    SCS_ST_WAIT  = 2'b01,
    SCS_ST_VALID = 2'b10
  } scs_settle_t;

  typedef enum logic
  {
    SCS_SRC_INT = 1'b0,
    SCS_SRC_EXT = 1'b1
  } scs_src_t;

  typedef struct packed
  {
    logic osc_enable;
    logic system_clock_source_select;
  } scs_int_ctrl_t;

  typedef struct packed
  {
    scs_xmode_t mode;
    logic [2:0] ext_osc_freq_control;
  } scs_ext_ctrl_t;

  typedef struct packed
  {
    logic crystal_in_pin_taken;
    logic crystal_out_pin_taken;
  } scs_pins_t;

  localparam scs_int_ctrl_t INT_CTRL_RST = '{osc_enable: 1'b1,
    system_clock_source_select: 1'b0};
  localparam scs_ext_ctrl_t EXT_CTRL_RST = '{mode: SCS_XM_OFF,
    ext_osc_freq_control: 3'h0};
  localparam scs_pins_t     PINS_RST     = '{crystal_in_pin_taken: 1'b0,
    crystal_out_pin_taken: 1'b0};

endpackage

// File: rtl/scs_settle.sv
module scs_settle
  import scs_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             osc_pin,
  input  scs_xmode_t            mode_next,
  input  wire logic [CNT_W-1:0] min_wait,
  output logic                  tick,
  output logic                  valid
);

  function automatic logic [CNT_W-1:0] need_edges(input scs_xmode_t m);
    if (m == SCS_XM_CRYSTAL)
      need_edges = CNT_W'(XTAL_SETTLE_EDGES);
    else
      need_edges = CNT_W'(QUICK_SETTLE_EDGES);
  endfunction

  logic             sync1_q, sync1_d;
  logic             sync2_q, sync2_d;
  logic             sync3_q, sync3_d;
  logic             tick_q,  tick_d;
  scs_settle_t      state_q, state_d;
  scs_xmode_t       mode_q,  mode_d;
  logic [CNT_W-1:0] wait_q,  wait_d;
  logic [CNT_W-1:0] edges_q, edges_d;
  logic [CNT_W-1:0] wait_need;
  logic             edge_seen;

  always_comb
  begin
    sync1_d   = osc_pin;
    sync2_d   = sync1_q;
    sync3_d   = sync2_q;
    edge_seen = sync2_q & ~sync3_q;
    mode_d    = mode_next;
    state_d   = state_q;
    wait_d    = wait_q;
    edges_d   = edges_q;
    wait_need = (mode_next == SCS_XM_CRYSTAL) ? min_wait : '0;
    // peripherals get the oscillator whatever the system clock is
    tick_d    = edge_seen && (mode_next != SCS_XM_OFF);
    case (state_q)
      SCS_ST_IDLE:
      begin
        wait_d  = '0;
        edges_d = '0;
        if (mode_next != SCS_XM_OFF)
          state_d = SCS_ST_WAIT;
      end
      SCS_ST_WAIT:
      begin
        if (wait_q < wait_need)
          wait_d = wait_q + CNT_W'(1);
        if (edge_seen && edges_q < need_edges(mode_next))
          edges_d = edges_q + CNT_W'(1);
        if (wait_q >= wait_need && edges_q >= need_edges(mode_next))
          state_d = SCS_ST_VALID;
      end
      SCS_ST_VALID:
        state_d = SCS_ST_VALID;
      default:
        state_d = SCS_ST_IDLE;
    endcase
    if (mode_next == SCS_XM_OFF || mode_next != mode_q)
    begin
      state_d = SCS_ST_IDLE;
      wait_d  = '0;
      edges_d = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      tick_q  <= 1'b0;
      state_q <= SCS_ST_IDLE;
      mode_q  <= SCS_XM_OFF;
      wait_q  <= '0;
      edges_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      tick_q  <= tick_d;
      state_q <= state_d;
      mode_q  <= mode_d;
      wait_q  <= wait_d;
      edges_q <= edges_d;
    end
  end

  assign tick  = tick_q;
  assign valid = (state_q == SCS_ST_VALID);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  valid_cleared_off_a:
    assert property (mode_next == SCS_XM_OFF |=> !valid)
    else $error("valid flag set while oscillator off");

  xtal_wait_held_a:
    assert property ($rose(valid) && mode_q == SCS_XM_CRYSTAL
                     |-> $past(wait_q) >= min_wait)
    else $error("crystal valid before least wait");

  valid_needs_edges_a:
    assert property ($rose(valid) |-> $past(edges_q) >= need_edges(mode_q))
    else $error("valid flag rose without settling edges");

  periph_tick_a:
    assert property (sync2_q && !sync3_q && mode_next != SCS_XM_OFF
                     |=> tick)
    else $error("oscillator edge not passed to peripherals");

endmodule // scs_settle

// File: rtl/scs_top.sv
// How it works
// - external clock only while select bit is one
// - external oscillator still clocks peripherals
// - switch only to enabled, settled source
// - enable and select internal in one write
// - hardware sets crystal valid once settled
// - crystal mode takes both crystal pins
// - RC, capacitor, CMOS modes take output pin
module scs_top
  import scs_pkg::*;
#(
  parameter int unsigned XTAL_WAIT_CYCLES = XTAL_WAIT_CYC
)
(
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire logic     int_ctrl_we,
  input  scs_int_ctrl_t int_ctrl_wdata,
  input  wire logic     ext_ctrl_we,
  input  scs_ext_ctrl_t ext_ctrl_wdata,
  input  wire logic     ext_osc_pin,
  output scs_int_ctrl_t internal_osc_control_reg,
  output scs_ext_ctrl_t external_osc_control_reg,
  output logic          crystal_valid_flag,
  output logic          sysclk_from_ext,
  output logic          switch_pending,
  output logic          switch_done,
  output logic          periph_ext_tick,
  output scs_pins_t     pins_taken
);

  scs_int_ctrl_t int_q,      int_d;
  scs_ext_ctrl_t ext_q,      ext_d;
  scs_src_t      src_q,      src_d;
  scs_pins_t     pins_q,     pins_d;
  logic          pending_q,  pending_d;
  logic          switched_q, switched_d;
  logic          ext_ok;
  logic          xtal_valid;
  logic          ext_tick;

  scs_settle u_settle
  (
    .clock     (clock),
    .rst       (rst),
    .osc_pin   (ext_osc_pin),
    .mode_next (ext_d.mode),
    .min_wait  (CNT_W'(XTAL_WAIT_CYCLES)),
    .tick      (ext_tick),
    .valid     (xtal_valid)
  );

  always_comb
  begin
    int_d = int_q;
    ext_d = ext_q;
    if (int_ctrl_we)
      int_d = int_ctrl_wdata;
    if (ext_ctrl_we)
      ext_d = ext_ctrl_wdata;
    // a mode change this cycle makes the external source unusable
    ext_ok = xtal_valid && (ext_q.mode != SCS_XM_OFF)
             && (ext_d.mode == ext_q.mode);
    src_d = src_q;
    case (src_q)
      SCS_SRC_INT:
        if (int_d.system_clock_source_select && ext_ok)
          src_d = SCS_SRC_EXT;
      SCS_SRC_EXT:
        if (!ext_ok || !int_d.system_clock_source_select)
          src_d = SCS_SRC_INT;
      default:
        src_d = SCS_SRC_INT;
    endcase
    // losing the external source drops back to the internal one
    if (src_q == SCS_SRC_EXT && !ext_ok)
      int_d.system_clock_source_select = 1'b0;
    // the internal oscillator cannot stop while it is the system clock
    if (src_d == SCS_SRC_INT)
      int_d.osc_enable = 1'b1;
    // a refused select stays pending until the source settles
    pending_d  = int_d.system_clock_source_select
                 != (src_d == SCS_SRC_EXT);
    switched_d = (src_d != src_q);
    // pins follow the mode that lands at this edge
    case (ext_d.mode)
      SCS_XM_CRYSTAL:
        pins_d = '{crystal_in_pin_taken: 1'b1,
                   crystal_out_pin_taken: 1'b1};
      SCS_XM_RC, SCS_XM_CAP, SCS_XM_CMOS:
        pins_d = '{crystal_in_pin_taken: 1'b0,
                   crystal_out_pin_taken: 1'b1};
      default:
        pins_d = PINS_RST;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      int_q      <= INT_CTRL_RST;
      ext_q      <= EXT_CTRL_RST;
      src_q      <= SCS_SRC_INT;
      pins_q     <= PINS_RST;
      pending_q  <= 1'b0;
      switched_q <= 1'b0;
    end
    else
    begin
      int_q      <= int_d;
      ext_q      <= ext_d;
      src_q      <= src_d;
      pins_q     <= pins_d;
      pending_q  <= pending_d;
      switched_q <= switched_d;
    end
  end

  // every output but the tick and valid comes straight from this module
  assign internal_osc_control_reg = int_q;
  assign external_osc_control_reg = ext_q;
  assign crystal_valid_flag       = xtal_valid;
  assign sysclk_from_ext          = (src_q == SCS_SRC_EXT);
  assign switch_pending           = pending_q;
  assign switch_done              = switched_q;
  assign periph_ext_tick          = ext_tick;
  assign pins_taken               = pins_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ext_needs_select_a:
    assert property (sysclk_from_ext
                     |-> internal_osc_control_reg.system_clock_source_select)
    else $error("external clock without select bit");

  deselect_goes_int_a:
    assert property (int_ctrl_we
                     && !int_ctrl_wdata.system_clock_source_select
                     |=> !sysclk_from_ext)
    else $error("select bit cleared but external clock kept");

  ext_only_settled_a:
    assert property ($rose(sysclk_from_ext) |-> $past(xtal_valid))
    else $error("switched to an unsettled external source");

  refuse_unsettled_a:
    assert property (!sysclk_from_ext && !xtal_valid
                     |=> !sysclk_from_ext)
    else $error("external source taken while not valid");

  ext_fallback_a:
    assert property (sysclk_from_ext && ext_ctrl_we
                     && ext_ctrl_wdata.mode != ext_q.mode
                     |=> !sysclk_from_ext && int_q.osc_enable
                         && !int_q.system_clock_source_select)
    else $error("no fallback after external source lost");

  single_write_a:
    assert property (int_ctrl_we && int_ctrl_wdata.osc_enable
                     && !int_ctrl_wdata.system_clock_source_select
                     |=> !sysclk_from_ext && int_q.osc_enable
                         && !int_q.system_clock_source_select)
    else $error("internal enable and select in one write failed");

  pending_shows_a:
    assert property (int_ctrl_we
                     && int_ctrl_wdata.system_clock_source_select
                     && !xtal_valid && !sysclk_from_ext
                     |=> switch_pending && !sysclk_from_ext)
    else $error("refused switch not shown as pending");

  crystal_pins_a:
    assert property (ext_q.mode == SCS_XM_CRYSTAL
                     |-> pins_taken.crystal_in_pin_taken
                         && pins_taken.crystal_out_pin_taken)
    else $error("crystal mode does not take both pins");

  out_pin_only_a:
    assert property ((ext_q.mode == SCS_XM_RC || ext_q.mode == SCS_XM_CAP
                      || ext_q.mode == SCS_XM_CMOS)
                     |-> !pins_taken.crystal_in_pin_taken
                         && pins_taken.crystal_out_pin_taken)
    else $error("single pin mode takes wrong pins");

  off_clears_valid_a:
    assert property (ext_ctrl_we && ext_ctrl_wdata.mode == SCS_XM_OFF
                     |=> !crystal_valid_flag && !sysclk_from_ext)
    else $error("valid flag kept after oscillator off");

  int_kept_on_a:
    assert property (!sysclk_from_ext
                     |-> internal_osc_control_reg.osc_enable)
    else $error("internal oscillator off while system clock");

  pins_free_off_a:
    assert property (ext_q.mode == SCS_XM_OFF
                     |-> !pins_taken.crystal_in_pin_taken
                         && !pins_taken.crystal_out_pin_taken)
    else $error("pins taken while oscillator off");

  valid_needs_mode_a:
    assert property (ext_q.mode == SCS_XM_OFF
                     |-> !crystal_valid_flag)
    else $error("valid flag up while oscillator off");

  tick_needs_mode_a:
    assert property (ext_q.mode == SCS_XM_OFF
                     |-> !periph_ext_tick)
    else $error("peripheral tick while oscillator off");

  switch_done_pulse_a:
    assert property (switch_done == $changed(sysclk_from_ext))
    else $error("switch done pulse out of step with source");

endmodule // scs_top

// File: sim/scs_osc_model.sv
module scs_osc_model
  import scs_pkg::*;
(
  input  wire logic       clock,
  input  scs_xmode_t      mode,
  input  wire logic [2:0] half,
  output logic            osc
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] cnt_q = 3'h0;

  initial osc = 1'b0;

  // oscillates only in the chosen mode, stands still while disabled
  always @(posedge clock)
  begin
    if (mode == SCS_XM_OFF)
    begin
      osc   <= 1'b0;
      cnt_q <= 3'h0;
    end
    else if (cnt_q >= half - 3'h1)
    begin
      osc   <= ~osc;
      cnt_q <= 3'h0;
    end
    else
      cnt_q <= cnt_q + 3'h1;
  end
endmodule // scs_osc_model

// File: sim/tb.sv
module tb
  import scs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int WAIT = 200;
  logic          clock       = 1'b0;
  logic          rst         = 1'b1;
  logic          int_ctrl_we = 1'b0;
  logic          ext_ctrl_we = 1'b0;
  scs_int_ctrl_t int_ctrl_wdata = INT_CTRL_RST;
  scs_ext_ctrl_t ext_ctrl_wdata = EXT_CTRL_RST;
  logic          ext_osc_pin;
  scs_int_ctrl_t internal_osc_control_reg;
  scs_ext_ctrl_t external_osc_control_reg;
  logic          crystal_valid_flag;
  logic          sysclk_from_ext;
  logic          switch_pending;
  logic          switch_done;
  logic          periph_ext_tick;
  scs_pins_t     pins_taken;
  logic [2:0]    half = 3'h3;
  logic [15:0]   lfsr = 16'h000b;
  int            error_cnt = 0;
  int            comparisons = 0;
  int            cyc = 0;
  int            n;
  scs_xmode_t    m;

  always #50 clock = ~clock;

  scs_top #(.XTAL_WAIT_CYCLES(WAIT)) dut_u (
    .clock(clock), .rst(rst), .int_ctrl_we(int_ctrl_we),
    .int_ctrl_wdata(int_ctrl_wdata), .ext_ctrl_we(ext_ctrl_we),
    .ext_ctrl_wdata(ext_ctrl_wdata), .ext_osc_pin(ext_osc_pin),
    .internal_osc_control_reg(internal_osc_control_reg),
    .external_osc_control_reg(external_osc_control_reg),
    .crystal_valid_flag(crystal_valid_flag),
    .sysclk_from_ext(sysclk_from_ext), .switch_pending(switch_pending),
    .switch_done(switch_done), .periph_ext_tick(periph_ext_tick),
    .pins_taken(pins_taken));

  scs_osc_model osc_u (
    .clock(clock), .mode(external_osc_control_reg.mode), .half(half),
    .osc(ext_osc_pin));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [1:0] exp_pins(input scs_xmode_t md);
    if (md == SCS_XM_OFF)
      return 2'h0;
    return (md == SCS_XM_CRYSTAL) ? 2'h3 : 2'h1;
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #10;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_int(input logic en, input logic sel);
    int_ctrl_wdata = '{osc_enable: en, system_clock_source_select: sel};
    int_ctrl_we = 1'b1;
    step(1);
    int_ctrl_we = 1'b0;
  endtask

  task automatic wr_ext(input scs_xmode_t md);
    ext_ctrl_wdata = '{mode: md, ext_osc_freq_control: lfsr[2:0]};
    lfsr = lfsr_next(lfsr);
    half = 3'h2 + {1'b0, lfsr[1:0]};
    ext_ctrl_we = 1'b1;
    step(1);
    ext_ctrl_we = 1'b0;
    chk(external_osc_control_reg, ext_ctrl_wdata);
    chk(pins_taken, exp_pins(md));
    if (md == SCS_XM_OFF)
      chk(crystal_valid_flag, 1'b0);
  endtask

  task automatic wait_valid();
    n = 0;
    while (crystal_valid_flag !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    chk(n < 400, 1'b1);
  endtask

  task automatic count_ticks();
    n = 0;
    repeat (40)
    begin
      step(1);
      n += (periph_ext_tick === 1'b1);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    step(6);
    rst = 1'b0;
    step(1);
    chk(internal_osc_control_reg, INT_CTRL_RST);
    chk(crystal_valid_flag, 1'b0);
    chk(pins_taken, 2'h0);
    chk(sysclk_from_ext, 1'b0);
    $display("test reset done");
    wr_ext(SCS_XM_CRYSTAL);
    wr_int(1'b1, 1'b1);
    chk(sysclk_from_ext, 1'b0);
    chk(switch_pending, 1'b1);
    step(WAIT);
    chk(crystal_valid_flag, 1'b0);
    wait_valid();
    step(2);
    chk(sysclk_from_ext, 1'b1);
    chk(switch_pending, 1'b0);
    $display("test crystal done");
    wr_int(1'b1, 1'b0);
    step(1);
    chk(sysclk_from_ext, 1'b0);
    chk(internal_osc_control_reg, 2'h2);
    count_ticks();
    chk(n > 0, 1'b1);
    wr_int(1'b0, 1'b0);
    step(1);
    chk(internal_osc_control_reg.osc_enable, 1'b1);
    $display("test internal done");
    repeat (2)
      for (int i = 0; i < 3; i++)
      begin
        m = (i == 0) ? SCS_XM_RC : (i == 1) ? SCS_XM_CAP : SCS_XM_CMOS;
        wr_ext(m);
        wait_valid();
        chk(n < WAIT, 1'b1);
        wr_int(1'b1, 1'b1);
        chk(switch_done, 1'b1);
        step(2);
        chk(sysclk_from_ext, 1'b1);
        chk(switch_done, 1'b0);
        wr_ext(SCS_XM_OFF);
        chk(sysclk_from_ext, 1'b0);
        chk(switch_done, 1'b1);
        step(1);
      end
    $display("test modes done");
    finish_test();
  end
endmodule // tb
